/* File: inc/plm_map.svh */
`ifndef PLM_MAP_SVH
`define PLM_MAP_SVH

// register indices; byte address is four times the index
`define PLM_IDX_CAP_ONE     8'h53
`define PLM_IDX_RES_THREE   8'h54
`define PLM_IDX_CAP_THREE   8'h55
`define PLM_IDX_MARGIN      8'h56

// field positions
`define PLM_CAP_MSB         2
`define PLM_CAP_LSB         0
`define PLM_RES_MSB         6
`define PLM_RES_LSB         1
`define PLM_FRAC_BIT        0
`define PLM_STEP_MSB        6
`define PLM_STEP_LSB        4
`define PLM_OPT_MSB         3
`define PLM_OPT_LSB         2

// reset values
`define PLM_RST_CAP         3'h0
`define PLM_RST_RES         6'h00
`define PLM_RST_FRAC        1'h0
`define PLM_RST_OPT         2'h0
`define PLM_RST_STEP        3'h0

// capacitor scaling in pF
`define PLM_C1_BASE_PF      9'h005
`define PLM_C1_UNIT_PF      9'h032
`define PLM_C3_UNIT_PF      6'h05

// margin step codes and options
`define PLM_STEP_NOMINAL    3'h3
`define PLM_OPT_GATED       2'h0
`define PLM_OPT_PIN         2'h1
`define PLM_OPT_SOFT        2'h2

// axi responses
`define PLM_RESP_OKAY       2'h0
`define PLM_RESP_DECERR     2'h3

`endif

/* File: inc/plm_pkg.sv */
package plm_pkg;

   typedef struct packed {
      logic [2:0] cap_one;
      logic [5:0] res_three;
      logic       frac_sel;
      logic [2:0] cap_three;
      logic [1:0] margin_opt;
   } plm_cfg_s;

   typedef struct packed {
      logic [2:0] step;
      logic       soft_ctrl;
   } plm_margin_s;

endpackage

/* File: hdl/plm_margin_sel.sv */
`timescale 1ns/1ns
module plm_margin_sel
   import plm_pkg::*;
#(
   parameter int STEP_W = 3
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   input  wire logic [1:0]        margin_opt,
   input  wire logic [STEP_W-1:0] margin_step_pin,
   input  wire logic              margin_gate_pin,
   output plm_margin_s            applied
);
`include "plm_map.svh"

   initial begin
      if (STEP_W != 3) $error("plm_margin_sel: STEP_W must be 3");
   end

   plm_margin_s st_r;
   plm_margin_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      unique case (margin_opt)
         `PLM_OPT_GATED: begin
            st_nxt.step      = margin_gate_pin ? `PLM_STEP_NOMINAL : margin_step_pin;
            st_nxt.soft_ctrl = 1'b0;
         end
         `PLM_OPT_PIN: begin
            st_nxt.step      = margin_step_pin;
            st_nxt.soft_ctrl = 1'b0;
         end
         `PLM_OPT_SOFT: begin
            st_nxt.step      = `PLM_STEP_NOMINAL;
            st_nxt.soft_ctrl = 1'b1;
         end
         default: begin
            st_nxt.step      = `PLM_STEP_NOMINAL;
            st_nxt.soft_ctrl = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r.step      <= `PLM_STEP_NOMINAL;
         st_r.soft_ctrl <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign applied = st_r;

endmodule // plm_margin_sel

/* File: hdl/plm_loop_regs.sv */
`timescale 1ns/1ns
// How it works
// - c1 equals 5 pF plus 50 pF times code
// - c3 equals 5 pF times code
// - six-bit resistor code in bits 6:1, resets zero
// - read-only bits 6:4 mirror step pin level
// - readback 0..6 means step 1..7, 3 nominal
// - option 0: gate high forces step code 3 (nominal)
module plm_loop_regs
   import plm_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [2:0]        margin_step_pin,
   input  wire logic              margin_gate_pin,
   output logic [2:0]             loop_cap_one_code,
   output logic [5:0]             loop_res_three_code,
   output logic                   loop_filter_frac_select,
   output logic [2:0]             loop_cap_three_code,
   output logic [8:0]             loop_cap_one_pf,
   output logic [5:0]             loop_cap_three_pf,
   output logic [2:0]             margin_step_applied,
   output logic                   margin_soft_control
);
`include "plm_map.svh"

   initial begin
      if (ADDR_W < 9 || ADDR_W > 32) $error("plm_loop_regs: ADDR_W must be 9..32");
   end

   localparam logic [ADDR_W-1:0] A_CAP_ONE   = ADDR_W'({`PLM_IDX_CAP_ONE, 2'b00});
   localparam logic [ADDR_W-1:0] A_RES_THREE = ADDR_W'({`PLM_IDX_RES_THREE, 2'b00});
   localparam logic [ADDR_W-1:0] A_CAP_THREE = ADDR_W'({`PLM_IDX_CAP_THREE, 2'b00});
   localparam logic [ADDR_W-1:0] A_MARGIN    = ADDR_W'({`PLM_IDX_MARGIN, 2'b00});

   typedef struct packed {
      plm_cfg_s          cfg;
      logic [2:0]        step_rb;
      logic [8:0]        c1_pf;
      logic [5:0]        c3_pf;
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [7:0]        w_byte;
      logic              w_lane;
      logic              awrdy;
      logic              wrdy;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arrdy;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } plm_state_s;

   plm_state_s  st_r;
   plm_state_s  st_nxt;
   plm_margin_s margin_q;

   always_comb begin
      st_nxt = st_r;

      // write address and data, in either order
      if (s_axi_awvalid && st_r.awrdy) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wrdy) begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_byte = s_axi_wdata[7:0];
         st_nxt.w_lane = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = `PLM_RESP_OKAY;
         unique case (st_r.aw_addr)
            A_CAP_ONE: begin
               if (st_r.w_lane) begin
                  st_nxt.cfg.cap_one = st_r.w_byte[`PLM_CAP_MSB:`PLM_CAP_LSB];
               end
            end
            A_RES_THREE: begin
               if (st_r.w_lane) begin
                  st_nxt.cfg.res_three = st_r.w_byte[`PLM_RES_MSB:`PLM_RES_LSB];
                  st_nxt.cfg.frac_sel  = st_r.w_byte[`PLM_FRAC_BIT];
               end
            end
            A_CAP_THREE: begin
               if (st_r.w_lane) begin
                  st_nxt.cfg.cap_three = st_r.w_byte[`PLM_CAP_MSB:`PLM_CAP_LSB];
               end
            end
            A_MARGIN: begin
               if (st_r.w_lane) begin
                  st_nxt.cfg.margin_opt = st_r.w_byte[`PLM_OPT_MSB:`PLM_OPT_LSB];
               end
            end
            default: begin
               st_nxt.bresp = `PLM_RESP_DECERR;
            end
         endcase
      end
      st_nxt.awrdy = !st_nxt.aw_held && !st_nxt.bvalid;
      st_nxt.wrdy  = !st_nxt.w_held && !st_nxt.bvalid;

      // read channel
      if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arrdy) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = `PLM_RESP_OKAY;
         st_nxt.rdata  = 32'h0000_0000;
         unique case (s_axi_araddr)
            A_CAP_ONE: begin
               st_nxt.rdata[`PLM_CAP_MSB:`PLM_CAP_LSB] = st_r.cfg.cap_one;
            end
            A_RES_THREE: begin
               st_nxt.rdata[`PLM_RES_MSB:`PLM_RES_LSB] = st_r.cfg.res_three;
               st_nxt.rdata[`PLM_FRAC_BIT]              = st_r.cfg.frac_sel;
            end
            A_CAP_THREE: begin
               st_nxt.rdata[`PLM_CAP_MSB:`PLM_CAP_LSB] = st_r.cfg.cap_three;
            end
            A_MARGIN: begin
               st_nxt.rdata[`PLM_STEP_MSB:`PLM_STEP_LSB] = st_r.step_rb;
               st_nxt.rdata[`PLM_OPT_MSB:`PLM_OPT_LSB]   = st_r.cfg.margin_opt;
            end
            default: begin
               st_nxt.rresp = `PLM_RESP_DECERR;
            end
         endcase
      end
      st_nxt.arrdy = !st_nxt.rvalid;

      st_nxt.step_rb = margin_step_pin;
      st_nxt.c1_pf = `PLM_C1_BASE_PF
                   + 9'(`PLM_C1_UNIT_PF * {6'h00, st_nxt.cfg.cap_one});
      st_nxt.c3_pf = 6'(`PLM_C3_UNIT_PF * {3'h0, st_nxt.cfg.cap_three});
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r            <= '0;
         st_r.cfg        <= {`PLM_RST_CAP, `PLM_RST_RES, `PLM_RST_FRAC,
                             `PLM_RST_CAP, `PLM_RST_OPT};
         st_r.step_rb    <= `PLM_RST_STEP;
         st_r.c1_pf      <= `PLM_C1_BASE_PF;
         st_r.awrdy      <= 1'b1;
         st_r.wrdy       <= 1'b1;
         st_r.arrdy      <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   plm_margin_sel #(
      .STEP_W (3)
   ) u_margin (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .ce              (ce),
      .margin_opt      (st_r.cfg.margin_opt),
      .margin_step_pin (margin_step_pin),
      .margin_gate_pin (margin_gate_pin),
      .applied         (margin_q)
   );

   assign s_axi_awready           = st_r.awrdy;
   assign s_axi_wready            = st_r.wrdy;
   assign s_axi_bvalid            = st_r.bvalid;
   assign s_axi_bresp             = st_r.bresp;
   assign s_axi_arready           = st_r.arrdy;
   assign s_axi_rvalid            = st_r.rvalid;
   assign s_axi_rdata             = st_r.rdata;
   assign s_axi_rresp             = st_r.rresp;
   assign loop_cap_one_code       = st_r.cfg.cap_one;
   assign loop_res_three_code     = st_r.cfg.res_three;
   assign loop_filter_frac_select = st_r.cfg.frac_sel;
   assign loop_cap_three_code     = st_r.cfg.cap_three;
   assign loop_cap_one_pf         = st_r.c1_pf;
   assign loop_cap_three_pf       = st_r.c3_pf;
   assign margin_step_applied     = margin_q.step;
   assign margin_soft_control     = margin_q.soft_ctrl;

endmodule // plm_loop_regs

/* File: tb/plm_loop_regs_assertions.sv */
`timescale 1ns/1ns
module plm_loop_regs_chk
   import plm_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [2:0]  margin_step_pin,
   input wire logic [2:0]  loop_cap_one_code,
   input wire logic [2:0]  loop_cap_three_code,
   input wire logic [8:0]  loop_cap_one_pf,
   input wire logic [5:0]  loop_cap_three_pf,
   input wire logic [2:0]  margin_step_applied
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_cap_one_pf: assert property (loop_cap_one_pf == 9'h005 + 9'h032 * loop_cap_one_code)
      else $error("c1 value wrong");
   a_cap_three_pf: assert property (loop_cap_three_pf == 6'h05 * loop_cap_three_code)
      else $error("c3 value wrong");
   a_step_source: assert property (ce |=> margin_step_applied == 3'h3 ||
      margin_step_applied == $past(margin_step_pin)) else $error("applied step wrong");
   a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h3);
   cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
   cover property (margin_step_applied != 3'h3);
endmodule // plm_loop_regs_chk

bind plm_loop_regs plm_loop_regs_chk chk_u (
   .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .margin_step_pin, .loop_cap_one_code,
   .loop_cap_three_code, .loop_cap_one_pf, .loop_cap_three_pf, .margin_step_applied
);

/* File: tb/pll_loop_filter_margin_regs_test.sv */
`timescale 1ns/1ns
`include "plm_map.svh"
module pll_loop_filter_margin_regs_test import plm_pkg::*;;
   logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        margin_gate_pin = 1'b1, ce = 1'b1;
   bit          slow = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [2:0]  margin_step_pin = 3'h5, p;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        loop_filter_frac_select, margin_soft_control;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  loop_cap_one_code, loop_cap_three_code, margin_step_applied;
   logic [5:0]  loop_res_three_code, loop_cap_three_pf;
   logic [8:0]  loop_cap_one_pf;
   int          failures = 0, tests_run = 0, i;
   plm_loop_regs #(.ADDR_W(12)) dut_u (
      .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .margin_step_pin, .margin_gate_pin, .loop_cap_one_code, .loop_res_three_code,
      .loop_filter_frac_select, .loop_cap_three_code, .loop_cap_one_pf, .loop_cap_three_pf,
      .margin_step_applied, .margin_soft_control
   );
   always #5 aclk = ~aclk;
   task automatic final_report;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [11:0] adr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction
   task automatic wr(input logic [7:0] x, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= adr(x);
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
         n++;
      end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 50);
      s_axi_bready <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         check("bresp", s_axi_bresp, r);
      end else begin
         failures++;
         final_report();
      end
   endtask
   task automatic rd(input logic [7:0] x, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= adr(x);
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
         n++;
      end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 50);
      s_axi_rready <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         check("rdata", s_axi_rdata, d);
         check("rresp", s_axi_rresp, r);
      end else begin
         failures++;
         final_report();
      end
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      check("c1_pf", loop_cap_one_pf, 32'h5);
      check("step", margin_step_applied, 32'h3);
      rd(`PLM_IDX_RES_THREE, 32'h0, `PLM_RESP_OKAY);
      rd(`PLM_IDX_MARGIN, 32'h50, `PLM_RESP_OKAY);
      for (i = 0; i < 8; i++) begin
         wr(`PLM_IDX_CAP_ONE, 32'hffff_fff8 | i, 4'hf, `PLM_RESP_OKAY);
         wr(`PLM_IDX_CAP_THREE, 32'hffff_ffff ^ i, 4'hf, `PLM_RESP_OKAY);
         rd(`PLM_IDX_CAP_ONE, i, `PLM_RESP_OKAY);
         rd(`PLM_IDX_CAP_THREE, 7 - i, `PLM_RESP_OKAY);
         check("c1_pf", loop_cap_one_pf, 5 + 50 * i);
         check("c3_pf", loop_cap_three_pf, 5 * (7 - i));
      end
      wr(`PLM_IDX_RES_THREE, 32'hff, 4'hf, `PLM_RESP_OKAY);
      rd(`PLM_IDX_RES_THREE, 32'h7f, `PLM_RESP_OKAY);
      check("res", loop_res_three_code, 32'h3f);
      check("frac", loop_filter_frac_select, 32'h1);
      wr(`PLM_IDX_RES_THREE, 32'hd4, 4'hf, `PLM_RESP_OKAY);
      rd(`PLM_IDX_RES_THREE, 32'h54, `PLM_RESP_OKAY);
      check("res", loop_res_three_code, 32'h2a);
      check("frac", loop_filter_frac_select, 32'h0);
      wr(`PLM_IDX_CAP_ONE, 32'h2, 4'h0, `PLM_RESP_OKAY);
      rd(`PLM_IDX_CAP_ONE, 32'h7, `PLM_RESP_OKAY);
      // late ready: answers must stand until taken
      slow = 1'b1;
      wr(`PLM_IDX_CAP_THREE, 32'h5, 4'hf, `PLM_RESP_OKAY);
      rd(`PLM_IDX_CAP_THREE, 32'h5, `PLM_RESP_OKAY);
      slow = 1'b0;
      check("c3_pf", loop_cap_three_pf, 32'h19);
      wr(8'h57, 32'h1, 4'hf, `PLM_RESP_DECERR);
      rd(8'h57, 32'h0, `PLM_RESP_DECERR);
      for (i = 0; i < 8; i++) begin
         p = i[2:0] ^ 3'h4;
         margin_step_pin <= p;
         margin_gate_pin <= i[0];
         wr(`PLM_IDX_MARGIN, {28'hf, i[2:1], 2'h3}, 4'hf, `PLM_RESP_OKAY);
         rd(`PLM_IDX_MARGIN, {25'h0, p, i[2:1], 2'h0}, `PLM_RESP_OKAY);
         check("step", margin_step_applied, (i[2:1] == 1 || i == 0) ? p : 3);
         check("soft", margin_soft_control, i[2:1] == 2);
      end
      // clock enable low freezes the applied step
      margin_step_pin <= 3'h6;
      wr(`PLM_IDX_MARGIN, 32'h4, 4'hf, `PLM_RESP_OKAY);
      ce <= 1'b0;
      margin_step_pin <= 3'h1;
      repeat (4) @(posedge aclk);
      check("step_hold", margin_step_applied, 32'h6);
      ce <= 1'b1;
      repeat (2) @(posedge aclk);
      check("step", margin_step_applied, 32'h1);
      // reset in mid-run
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      check("res", loop_res_three_code, 32'h0);
      check("c1_pf", loop_cap_one_pf, 32'h5);
      check("step", margin_step_applied, 32'h3);
      rd(`PLM_IDX_RES_THREE, 32'h0, `PLM_RESP_OKAY);
      final_report();
   end
endmodule // pll_loop_filter_margin_regs_test
